// file: core/rfpfr_pkg.sv
package rfpfr_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_NET = 8'h0C;
  localparam logic [7:0] OFS_PKT = 8'h10;
  localparam logic [7:0] OFS_BURST = 8'h14;
  localparam logic [7:0] OFS_TOUT = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_CNT = 8'h24;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RETRY_LSB = 4;
  localparam int ADDR_SRC_LSB = 0;
  localparam int ADDR_DST_LSB = 16;
  localparam int NET_PRE_LSB = 0;
  localparam int NET_VEN_LSB = 16;
  localparam int PKT_MAX_LSB = 0;
  localparam int PKT_THR_LSB = 16;
  localparam int BURST_TT_LSB = 0;
  localparam int BURST_RN_LSB = 16;

  // ****************************************************
  // Values after reset, broadcast address and relay length limit
  // ****************************************************
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [3:0] RST_RETRY = 4'h0;
  localparam logic [15:0] RST_SRC = 16'hFFFF;
  localparam logic [15:0] RST_DST = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [7:0] RST_PRE = 8'h00;
  localparam logic [15:0] RST_VEN = 16'h0000;
  localparam logic [8:0] RST_MAXPK = 9'h100;
  localparam logic [8:0] RST_THR = 9'h100;
  localparam logic [15:0] RST_TT = 16'hFFFF;
  localparam logic [7:0] RST_RN = 8'h00;
  localparam logic [15:0] RST_TOUT = 16'h0100;
  localparam logic [15:0] BCAST_ADDR = 16'hFFFF;
  localparam logic [8:0] RPT_MAX_LEN = 9'h100;

  // ****************************************************
  // Modes, timing and identifier history size
  // ****************************************************
  localparam logic [2:0] MODE_REPEATER = 3'h3;
  localparam logic [2:0] MODE_DEST = 3'h4;
  localparam int CLK_HZ = 125_000_000;
  localparam int SYNC_MS = 35;
  localparam int COLD_MS = 50;
  localparam int SYNC_CYCLES = SYNC_MS * (CLK_HZ / 1000);
  localparam int COLD_CYCLES = COLD_MS * (CLK_HZ / 1000);
  localparam int PID_DEPTH = 8;
  localparam int PID_W = 24;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_NEXT} rfpfr_tx_e;

endpackage : rfpfr_pkg

// file: core/rfpfr_lfsr.sv
`timescale 1ns/10ps
`default_nettype none

module rfpfr_lfsr
  import rfpfr_pkg::*;
#(
  parameter int W = 16
)(
  input wire logic pclk,
  input wire logic presetn,
  output logic [W-1:0] value
);

  generate
    if (W != 16)
    begin : g_chk
      $error("rfpfr_lfsr taps are defined for W = 16 only");
    end
  endgenerate

  // Free running so the draw depends on when a back-off begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value <= 16'hACE1;
    else
      value <= {1'b0, value[W-1:1]} ^ (value[0] ? 16'hB400 : 16'h0000);
  end

endmodule : rfpfr_lfsr

`default_nettype wire

// file: core/rfpfr_pid_hist.sv
`timescale 1ns/10ps
`default_nettype none

module rfpfr_pid_hist
  import rfpfr_pkg::*;
#(
  parameter int DEPTH = PID_DEPTH,
  parameter int W = PID_W
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] lookup_id,
  input wire logic insert,
  output logic hit
);

  logic [W-1:0] id_mem [DEPTH];
  logic [DEPTH-1:0] used;

  generate
    if (DEPTH < 1)
    begin : g_chk
      $error("rfpfr_pid_hist needs at least one entry");
    end
  endgenerate

  always_comb
  begin
    hit = 1'b0;
    for (int i = 0; i < DEPTH; i++)
      if (used[i] && id_mem[i] == lookup_id)
        hit = 1'b1;
  end

  // Newest at index 0; the last entry falls out when full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      used <= '0;
      for (int i = 0; i < DEPTH; i++)
        id_mem[i] <= '0;
    end
    else if (insert)
    begin
      used <= {used[DEPTH-2:0], 1'b1};
      id_mem[0] <= lookup_id;
      for (int i = 1; i < DEPTH; i++)
        id_mem[i] <= id_mem[i-1];
    end
  end

endmodule : rfpfr_pid_hist

`default_nettype wire

// file: core/rfpfr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module rfpfr_ctrl
  import rfpfr_pkg::*;
#(
  parameter int SYNC_WAIT = SYNC_CYCLES,
  parameter int COLD_WAIT = COLD_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] serial_number,
  input wire logic rx_valid,
  input wire logic [7:0] rx_preamble,
  input wire logic [15:0] rx_vendor,
  input wire logic [15:0] rx_dest,
  input wire logic [15:0] rx_src,
  input wire logic [7:0] rx_serial,
  input wire logic [8:0] rx_len,
  input wire logic [15:0] rx_air_cycles,
  input wire logic rx_event_end,
  output logic rx_deliver,
  output logic rx_drop,
  input wire logic [15:0] tx_buf_count,
  input wire logic tx_done,
  input wire logic [15:0] tx_air_cycles,
  output logic tx_start,
  output logic [8:0] tx_len,
  output logic tx_with_init,
  output logic tx_repeat,
  output logic tx_global,
  output logic [15:0] tx_orig_src,
  output logic [7:0] tx_serial,
  output logic [3:0] tx_retry_count,
  output logic link_synced
);

  generate
    if (SYNC_WAIT < 1 || COLD_WAIT < SYNC_WAIT)
    begin : g_chk
      $error("rfpfr_ctrl needs 1 <= SYNC_WAIT <= COLD_WAIT");
    end
  endgenerate

  // ****************************************************
  // Configuration registers
  // ****************************************************
  logic [2:0] rf_mode_select;
  logic [3:0] retry_count;
  logic [15:0] source_addr, dest_addr, addr_mask, network_vendor_code;
  logic [7:0] preamble_code, backoff_slot_count;
  logic [8:0] max_packet_size, packetize_byte_threshold;
  logic [15:0] burst_byte_limit, packetize_timeout;
  logic [15:0] deliver_cnt, drop_cnt;
  logic auto_source_addr_cmd;
  logic wr_en, rd_en, addr_ok;
  logic [31:0] wmask, rd_mux, wr_word;
  logic is_rptr, streaming;
  logic load_hold, holdoff_active, tx_busy;

  assign is_rptr = (rf_mode_select == MODE_REPEATER) || (rf_mode_select == MODE_DEST);
  assign streaming = !is_rptr;
  // Writes land only at the edge that completes the transfer
  assign wr_en = psel && penable && pwrite && pready && addr_ok;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign auto_source_addr_cmd = wr_en && paddr == OFS_CMD && pstrb[0] && pwdata[0];
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {24'h0, retry_count, 1'b0, rf_mode_select};
      OFS_ADDR: rd_mux = {dest_addr, source_addr};
      OFS_MASK: rd_mux = {16'h0, addr_mask};
      OFS_NET: rd_mux = {network_vendor_code, 8'h0, preamble_code};
      OFS_PKT: rd_mux = {7'h0, packetize_byte_threshold, 7'h0, max_packet_size};
      OFS_BURST: rd_mux = {8'h0, backoff_slot_count, burst_byte_limit};
      OFS_TOUT: rd_mux = {16'h0, packetize_timeout};
      OFS_CMD: rd_mux = 32'h0000_0000;
      OFS_STAT: rd_mux = {28'h0, 1'b0, link_synced, tx_busy, holdoff_active};
      OFS_CNT: rd_mux = {drop_cnt, deliver_cnt};
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en)
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  assign wr_word = merge(rd_mux, pwdata, wmask);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rf_mode_select <= RST_MODE;
      retry_count <= RST_RETRY;
      source_addr <= RST_SRC;
      dest_addr <= RST_DST;
      addr_mask <= RST_MASK;
      preamble_code <= RST_PRE;
      network_vendor_code <= RST_VEN;
      max_packet_size <= RST_MAXPK;
      packetize_byte_threshold <= RST_THR;
      burst_byte_limit <= RST_TT;
      backoff_slot_count <= RST_RN;
      packetize_timeout <= RST_TOUT;
    end
    else if (auto_source_addr_cmd)
      source_addr <= serial_number;
    else if (wr_en)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          rf_mode_select <= wr_word[CTRL_MODE_LSB +: 3];
          retry_count <= wr_word[CTRL_RETRY_LSB +: 4];
        end
        OFS_ADDR:
        begin
          source_addr <= wr_word[ADDR_SRC_LSB +: 16];
          dest_addr <= wr_word[ADDR_DST_LSB +: 16];
        end
        OFS_MASK: addr_mask <= wr_word[15:0];
        OFS_NET:
        begin
          preamble_code <= wr_word[NET_PRE_LSB +: 8];
          network_vendor_code <= wr_word[NET_VEN_LSB +: 16];
        end
        OFS_PKT:
        begin
          max_packet_size <= wr_word[PKT_MAX_LSB +: 9];
          packetize_byte_threshold <= wr_word[PKT_THR_LSB +: 9];
        end
        OFS_BURST:
        begin
          burst_byte_limit <= wr_word[BURST_TT_LSB +: 16];
          backoff_slot_count <= wr_word[BURST_RN_LSB +: 8];
        end
        OFS_TOUT: packetize_timeout <= wr_word[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // Start-up timing
  // ****************************************************
  logic [31:0] up_cnt;
  logic tx_allowed;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_cnt <= 32'h0000_0000;
      link_synced <= 1'b0;
      tx_allowed <= 1'b0;
    end
    else
    begin
      if (!tx_allowed)
        up_cnt <= up_cnt + 32'h0000_0001;
      link_synced <= link_synced || (up_cnt >= 32'(SYNC_WAIT - 1));
      tx_allowed <= tx_allowed || (up_cnt >= 32'(COLD_WAIT - 1));
    end
  end

  // ****************************************************
  // Back-off slot timer
  // ****************************************************
  logic [15:0] rnd, slot_len, slot_cyc;
  logic [8:0] hold_slots, load_slots;
  logic [7:0] rnd_mod;

  rfpfr_lfsr #(.W(16)) u_lfsr (
    .pclk(pclk),
    .presetn(presetn),
    .value(rnd)
  );

  // Modulo by the slot setting keeps the draw uniform enough for 8 bits
  assign rnd_mod = (backoff_slot_count == 8'h00) ? 8'h00 : rnd[7:0] % backoff_slot_count;
  assign holdoff_active = hold_slots != 9'h000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_slots <= 9'h000;
      slot_cyc <= 16'h0000;
    end
    else if (load_hold && load_slots > hold_slots)
    begin
      hold_slots <= load_slots;
      slot_cyc <= slot_len;
    end
    else if (holdoff_active)
    begin
      if (slot_cyc <= 16'h0001)
      begin
        hold_slots <= hold_slots - 9'h001;
        slot_cyc <= slot_len;
      end
      else
        slot_cyc <= slot_cyc - 16'h0001;
    end
  end

  // ****************************************************
  // Receive filter and identifier history
  // ****************************************************
  logic net_ok, bcast, local_hit, global_hit, addr_hit, dup, own_pkt;
  logic [PID_W-1:0] rx_pid;
  logic rpt_pend;
  logic [8:0] rpt_len;
  logic [15:0] rpt_src;
  logic [7:0] rpt_serial;

  assign net_ok = rx_preamble == preamble_code && rx_vendor == network_vendor_code;
  assign bcast = rx_dest == BCAST_ADDR;
  assign local_hit = rx_dest == source_addr;
  assign global_hit = bcast || (addr_mask != 16'hFFFF && (rx_dest | addr_mask) == (source_addr | addr_mask));
  assign addr_hit = local_hit || global_hit;
  assign rx_pid = {rx_src, rx_serial};
  assign own_pkt = rx_src == source_addr;

  rfpfr_pid_hist #(.DEPTH(PID_DEPTH), .W(PID_W)) u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .lookup_id(rx_pid),
    .insert(rx_valid && net_ok && is_rptr && !dup),
    .hit(dup)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_deliver <= 1'b0;
      rx_drop <= 1'b0;
      deliver_cnt <= 16'h0000;
      drop_cnt <= 16'h0000;
    end
    else
    begin
      // Streaming receivers never acknowledge, so nothing else answers a packet
      rx_deliver <= rx_valid && net_ok && addr_hit && !(is_rptr && dup);
      rx_drop <= rx_valid && !(net_ok && addr_hit && !(is_rptr && dup));
      if (rx_valid && net_ok && addr_hit && !(is_rptr && dup))
        deliver_cnt <= deliver_cnt + 16'h0001;
      else if (rx_valid)
        drop_cnt <= drop_cnt + 16'h0001;
    end
  end

  // One packet in flight at a time, so one pending relay is enough
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rpt_pend <= 1'b0;
      rpt_len <= 9'h000;
      rpt_src <= 16'h0000;
      rpt_serial <= 8'h00;
    end
    else if (rf_mode_select == MODE_REPEATER && rx_valid && net_ok && !dup && !own_pkt
      && rx_len <= RPT_MAX_LEN)
    begin
      rpt_pend <= 1'b1;
      rpt_len <= rx_len;
      rpt_src <= rx_src;
      rpt_serial <= rx_serial;
    end
    else if (tx_start && tx_repeat)
      rpt_pend <= 1'b0;
  end

  // ****************************************************
  // Transmit event sequencer
  // ****************************************************
  rfpfr_tx_e tx_state;
  logic [15:0] burst_bytes, idle_cyc, last_count;
  logic [7:0] my_serial;
  logic first_ok, take_host, take_rpt;
  logic [8:0] next_len;

  assign tx_busy = tx_state != TX_IDLE;
  assign first_ok = tx_buf_count >= {7'h0, packetize_byte_threshold}
    || (tx_buf_count != 16'h0000 && idle_cyc >= packetize_timeout);
  // A hold-off still being loaded counts as active, so no start slips in ahead of it
  assign take_rpt = tx_state == TX_IDLE && tx_allowed && !holdoff_active && !load_hold && rpt_pend;
  assign take_host = tx_allowed && tx_buf_count != 16'h0000 && !take_rpt
    && ((tx_state == TX_IDLE && !holdoff_active && !load_hold && first_ok) || tx_state == TX_NEXT);
  assign next_len = (tx_buf_count > {7'h0, max_packet_size}) ? max_packet_size : tx_buf_count[8:0];

  // Timeout runs while the host buffer holds data without changing and no transmit event is busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cyc <= 16'h0000;
      last_count <= 16'h0000;
    end
    else
    begin
      last_count <= tx_buf_count;
      if (tx_buf_count != last_count || tx_buf_count == 16'h0000 || tx_busy)
        idle_cyc <= 16'h0000;
      else if (idle_cyc != 16'hFFFF)
        idle_cyc <= idle_cyc + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      tx_start <= 1'b0;
      tx_len <= 9'h000;
      tx_with_init <= 1'b0;
      tx_repeat <= 1'b0;
      tx_global <= 1'b0;
      tx_orig_src <= 16'h0000;
      tx_serial <= 8'h00;
      tx_retry_count <= 4'h0;
      burst_bytes <= 16'h0000;
      my_serial <= 8'h00;
      load_hold <= 1'b0;
      load_slots <= 9'h000;
      slot_len <= 16'h0001;
    end
    else
    begin
      tx_start <= 1'b0;
      load_hold <= 1'b0;
      tx_retry_count <= streaming ? 4'h0 : retry_count;
      if (rx_valid)
        slot_len <= (rx_air_cycles == 16'h0000) ? 16'h0001 : rx_air_cycles;
      if (rx_event_end && backoff_slot_count != 8'h00)
      begin
        load_hold <= 1'b1;
        load_slots <= (rf_mode_select == MODE_DEST) ? {1'b0, backoff_slot_count} + 9'h001
          : {1'b0, rnd_mod};
      end
      case (tx_state)
        TX_IDLE:
        begin
          burst_bytes <= 16'h0000;
          if (take_rpt)
          begin
            tx_start <= 1'b1;
            tx_len <= rpt_len;
            tx_with_init <= 1'b1;
            tx_repeat <= 1'b1;
            tx_orig_src <= rpt_src;
            tx_serial <= rpt_serial;
            tx_global <= 1'b1;
            tx_state <= TX_WAIT;
          end
          else if (take_host)
          begin
            tx_start <= 1'b1;
            tx_len <= is_rptr && next_len > RPT_MAX_LEN ? RPT_MAX_LEN : next_len;
            tx_with_init <= 1'b1;
            tx_repeat <= 1'b0;
            tx_orig_src <= source_addr;
            tx_serial <= my_serial;
            my_serial <= my_serial + 8'h01;
            tx_global <= dest_addr == BCAST_ADDR || (dest_addr & addr_mask) != dest_addr;
            tx_state <= TX_WAIT;
          end
        end
        TX_NEXT:
        begin
          // A relay is a single packet; host data waits for an event of its own
          if (take_host && !tx_repeat)
          begin
            tx_start <= 1'b1;
            tx_len <= next_len;
            tx_with_init <= 1'b0;
            tx_serial <= my_serial;
            my_serial <= my_serial + 8'h01;
            tx_state <= TX_WAIT;
          end
          else
          begin
            tx_state <= TX_IDLE;
            if (backoff_slot_count != 8'h00)
            begin
              load_hold <= 1'b1;
              load_slots <= {1'b0, backoff_slot_count};
            end
          end
        end
        TX_WAIT:
        begin
          if (tx_done)
          begin
            slot_len <= (tx_air_cycles == 16'h0000) ? 16'h0001 : tx_air_cycles;
            burst_bytes <= burst_bytes + {7'h0, tx_len};
            if (tx_repeat || rf_mode_select == MODE_DEST)
              tx_state <= TX_NEXT;
            else if (burst_bytes + {7'h0, tx_len} >= burst_byte_limit)
            begin
              tx_state <= TX_IDLE;
              load_hold <= 1'b1;
              load_slots <= {1'b0, rnd_mod} + 9'h001;
            end
            else
              tx_state <= TX_NEXT;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule : rfpfr_ctrl

`default_nettype wire

// file: dv/rfpfr_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none

module rfpfr_ctrl_props
  import rfpfr_pkg::*;
#(
  parameter int SYNC_WAIT = 20,
  parameter int COLD_WAIT = 40
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic rx_valid,
  input wire logic rx_deliver,
  input wire logic rx_drop,
  input wire logic tx_done,
  input wire logic tx_start,
  input wire logic [8:0] tx_len,
  input wire logic tx_with_init,
  input wire logic tx_repeat,
  input wire logic link_synced
);
  // ********
  // Edges since reset release; the sync checks allow one cycle of slack early and three late
  // ********
  logic [31:0] cyc;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc <= 32'h0;
    else
      cyc <= cyc + 32'h1;
  end

  a_rx_one_answer: assert property (rx_valid |=> rx_deliver ^ rx_drop) else $error("no single answer");
  a_rx_has_cause: assert property (rx_deliver || rx_drop |-> $past(rx_valid)) else $error("stray answer");
  a_next_no_init: assert property (tx_start && !tx_with_init |-> $past(tx_done, 2)) else $error("bad follow");
  a_relay_len: assert property (tx_start && tx_repeat |-> tx_len <= RPT_MAX_LEN) else $error("relay long");
  a_apb_ready: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
  a_sync_early: assert property (link_synced |-> cyc >= SYNC_WAIT - 1) else $error("synced early");
  a_sync_late: assert property (cyc >= SYNC_WAIT + 3 |-> link_synced) else $error("synced late");
  a_cold_tx: assert property (tx_start |-> cyc >= COLD_WAIT - 1) else $error("tx too early");
  c_deliver: cover property (rx_deliver);
  c_relay: cover property (tx_start && tx_repeat);
  c_follow: cover property (tx_start && !tx_with_init);
endmodule : rfpfr_ctrl_props

bind rfpfr_ctrl rfpfr_ctrl_props #(.SYNC_WAIT(SYNC_WAIT), .COLD_WAIT(COLD_WAIT)) rfpfr_ctrl_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .rx_valid(rx_valid),
  .rx_deliver(rx_deliver), .rx_drop(rx_drop), .tx_done(tx_done), .tx_start(tx_start), .tx_len(tx_len),
  .tx_with_init(tx_with_init), .tx_repeat(tx_repeat), .link_synced(link_synced));

`default_nettype wire

// file: dv/rfpfr_peer.sv
`timescale 1ns/10ps
`default_nettype none

module rfpfr_peer
  import rfpfr_pkg::*;
#(
  parameter int AIR = 6
)(
  input wire logic pclk,
  input wire logic tx_start,
  output logic rx_valid,
  output logic [7:0] rx_preamble,
  output logic [15:0] rx_vendor,
  output logic [15:0] rx_dest,
  output logic [15:0] rx_src,
  output logic [7:0] rx_serial,
  output logic [8:0] rx_len,
  output logic rx_event_end,
  output logic tx_done
);
  // ********
  // Far-side radio
  // ********
  int left = 0;

  initial
  begin
    {rx_valid, rx_event_end, tx_done} = 3'b000;
    {rx_preamble, rx_vendor, rx_dest, rx_src, rx_serial, rx_len} = '0;
  end

  // Air time varies so both prompt and slow peers are seen; nothing is ever acknowledged
  always @(posedge pclk)
  begin
    tx_done <= left == 1;
    rx_event_end <= rx_valid;
    if (tx_start)
      left <= AIR + int'($urandom_range(3));
    else if (left > 0)
      left <= left - 1;
  end

  // Header fields are inverted outside the valid cycle so stale values cannot pass
  task automatic send(input logic [7:0] pre, input logic [15:0] ven, dst, src, input logic [7:0] ser);
    @(posedge pclk);
    rx_valid <= 1'b1;
    {rx_preamble, rx_vendor, rx_dest, rx_src, rx_serial, rx_len} <= {pre, ven, dst, src, ser, 9'h020};
    @(posedge pclk);
    rx_valid <= 1'b0;
    {rx_preamble, rx_vendor, rx_dest, rx_src, rx_serial, rx_len} <= ~{pre, ven, dst, src, ser, 9'h020};
  endtask : send
endmodule : rfpfr_peer

`default_nettype wire

// file: dv/test_rf_packet_filter_repeater_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module test_rf_packet_filter_repeater_ctrl;
  import rfpfr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, nw;
  logic [7:0] paddr = 8'h00, rx_preamble, rx_serial, tx_serial;
  logic [3:0] pstrb = 4'hF, tx_retry_count;
  logic [31:0] pwdata = 32'h0, prdata, q, pv, b;
  logic [15:0] serial_number = 16'h0, tx_buf_count = 16'h0, rx_air_cycles = 16'h0006, tx_air_cycles = 16'h0006;
  logic [15:0] rx_vendor, rx_dest, rx_src, tx_orig_src, dst;
  logic pready, pslverr, rx_valid, rx_event_end, rx_deliver, rx_drop, tx_done, tx_start;
  logic tx_with_init, tx_repeat, tx_global, link_synced;
  logic [8:0] rx_len, tx_len;
  logic [23:0] id, hist[$];
  logic [31:0] rv[7] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h01000100, 32'hFFFF, 32'h100};
  int err_count = 0, n_tests = 0, k, j, c;

  rfpfr_ctrl #(.SYNC_WAIT(20), .COLD_WAIT(40)) rfpfr_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_number(serial_number), .rx_valid(rx_valid),
    .rx_preamble(rx_preamble), .rx_vendor(rx_vendor), .rx_dest(rx_dest), .rx_src(rx_src), .rx_serial(rx_serial),
    .rx_len(rx_len), .rx_air_cycles(rx_air_cycles), .rx_event_end(rx_event_end), .rx_deliver(rx_deliver),
    .rx_drop(rx_drop), .tx_buf_count(tx_buf_count), .tx_done(tx_done), .tx_air_cycles(tx_air_cycles),
    .tx_start(tx_start), .tx_len(tx_len), .tx_with_init(tx_with_init), .tx_repeat(tx_repeat),
    .tx_global(tx_global), .tx_orig_src(tx_orig_src), .tx_serial(tx_serial), .tx_retry_count(tx_retry_count),
    .link_synced(link_synced));
  rfpfr_peer #(.AIR(6)) rfpfr_peer_i (.pclk(pclk), .tx_start(tx_start), .rx_valid(rx_valid),
    .rx_preamble(rx_preamble), .rx_vendor(rx_vendor), .rx_dest(rx_dest), .rx_src(rx_src), .rx_serial(rx_serial),
    .rx_len(rx_len), .rx_event_end(rx_event_end), .tx_done(tx_done));

  always #4 pclk = ~pclk;

  // Host input buffer: a started host packet takes its bytes away; relays never came from it
  always @(posedge pclk)
  begin
    if (tx_start && !tx_repeat)
      tx_buf_count <= tx_buf_count - {7'h0, tx_len};
  end

  task automatic chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Waits on pready (0), tx_start (1) or tx_done (2); a hang counts and ends the run
  task automatic wait_hi(input int s);
    int i;
    i = 0;
    do
      @(posedge pclk);
    while ((s == 2 ? tx_done : (s == 1 ? tx_start : pready)) !== 1'b1 && ++i < 100);
    if (i >= 100)
    begin
      err_count++;
      summarize();
    end
  endtask : wait_hi

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(0);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // ********
  // Main sequence
  // ********
  initial
  begin
    k = $urandom(33728);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 7; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk(q, rv[k]);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({e, q[30:0]}, 32'h80000000);
    serial_number <= 16'($urandom);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk(q, {16'h0, serial_number});
    pv = $urandom & 32'hFFFF00FF;
    apb(1'b1, OFS_ADDR, 32'hFFFF1234);
    apb(1'b1, OFS_NET, pv);
    for (k = 0; k < 16; k++)
    begin
      b = $urandom;
      dst = b[3:2] == 2'h0 ? BCAST_ADDR : (b[3] ? b[31:16] : 16'h1234);
      nw = b[1:0] == 2'h0 && (dst == 16'h1234 || dst == BCAST_ADDR);
      rfpfr_peer_i.send(pv[7:0] ^ {7'h0, b[0]}, pv[31:16] ^ {15'h0, b[1]}, dst, 16'h0777, 8'(k));
      #1 chk({30'h0, rx_deliver, rx_drop}, {30'h0, nw, !nw});
    end
    // Nine fresh identifiers push the first out, so it is new again; the last one stays known
    apb(1'b1, OFS_CTRL, {29'h0, MODE_REPEATER});
    for (k = 0; k < 11; k++)
    begin
      j = k < 9 ? k : (k == 9 ? 0 : 8);
      id = {16'h0500 + 16'(j), 8'(j)};
      nw = !(id inside {hist});
      if (nw)
        hist.push_back(id);
      if (hist.size() > PID_DEPTH)
        hist.pop_front();
      rfpfr_peer_i.send(pv[7:0], pv[31:16], j[0] ? 16'h0BAD : BCAST_ADDR, id[23:8], id[7:0]);
      #1 chk({30'h0, rx_deliver, rx_drop}, {30'h0, nw && !j[0], !(nw && !j[0])});
      c = 0;
      repeat (40) @(posedge pclk) c += tx_start;
      chk(32'(c), {31'h0, nw});
      if (nw)
        chk({7'h0, tx_repeat, tx_orig_src, tx_serial}, {8'h01, id});
    end
    apb(1'b1, OFS_CTRL, 32'h50);
    apb(1'b1, OFS_PKT, 32'h00100010);
    apb(1'b1, OFS_BURST, 32'h0002FFFF);
    chk({28'h0, tx_retry_count}, 32'h0);
    tx_buf_count <= 16'h0028;
    for (k = 0; k < 3; k++)
    begin
      wait_hi(1);
      #1 chk({21'h0, tx_with_init, tx_global, tx_len}, {21'h0, k == 0, 1'b1, k[1] ? 9'h008 : 9'h010});
    end
    // Event ends with an empty buffer: two slots of one air time, plus three cycles to end and restart
    wait_hi(2);
    @(posedge pclk);
    tx_buf_count <= 16'h0010;
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (tx_start !== 1'b1 && c < 100);
    chk(32'(c), 32'(2 * 6 + 3));
    chk({31'h0, link_synced}, 32'h1);
    summarize();
  end
endmodule : test_rf_packet_filter_repeater_ctrl

`default_nettype wire
